// [common/ersq_pkg.sv]
// constants, states and alert groups of the emergency run sequencer
package ersq_pkg;
  // register byte offsets
  localparam logic [4:0] CTRL_OFF = 5'h00;
  localparam logic [4:0] SP_OFF = 5'h04;
  localparam logic [4:0] STAT_OFF = 5'h08;
  localparam logic [4:0] ALERT_OFF = 5'h0c;
  // control register fields
  localparam int CTRL_ACT_BIT = 0;
  localparam int CTRL_REMOTE_BIT = 1;
  localparam int CTRL_RRUN_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [15:0] SP_RST = 16'h0000;
  // status register fields
  localparam int STAT_EMERG_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_HOLD_BIT = 2;
  localparam int STAT_HALT_BIT = 3;
  localparam int STAT_SAVED_BIT = 4;
  localparam int STAT_KEYPAD_BIT = 5;
  // alert register fields
  localparam int ALERT_VALID_BIT = 16;
  localparam int ALERT_GRP_LSB = 20;
  localparam logic [15:0] ALERT_CODE_MAX = 16'hfde8;
  localparam logic [7:0] ALERT_NUMBER_ONE = 8'h01;
  // alert code group bounds
  localparam logic [15:0] GRP_EXC_LO = 16'h0001;
  localparam logic [15:0] GRP_EXC_HI = 16'h03e7;
  localparam logic [15:0] GRP_OVL_LO = 16'h03e9;
  localparam logic [15:0] GRP_OVL_HI = 16'h03eb;
  localparam logic [15:0] GRP_STACK = 16'h03ee;
  localparam logic [15:0] GRP_UNINIT = 16'h03f2;
  localparam logic [15:0] GRP_COMMS_LO = 16'h04b0;
  localparam logic [15:0] GRP_COMMS_HI = 16'h04b5;
  localparam logic [15:0] GRP_ETH_LO = 16'h0514;
  localparam logic [15:0] GRP_ETH_HI = 16'h0546;
  localparam logic [15:0] GRP_ALLOC_LO = 16'h07d0;
  localparam logic [15:0] GRP_ALLOC_HI = 16'h07d2;
  // trips: bit i carries trip id i+1; ids 1, 3 and 4 stay enabled
  localparam int TRIP_N = 37;
  localparam logic [36:0] TRIP_KEEP_MASK = 37'h00_0000_000d;
  // synchronised pin vector layout
  localparam int PIN_W = 43;
  localparam int PIN_COAST = 37;
  localparam int PIN_STO = 38;
  localparam int PIN_HWF = 39;
  localparam int PIN_LSTART = 40;
  localparam int PIN_LSTOP = 41;
  localparam int PIN_KEYPAD = 42;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ERSQ_NORMAL = 4'b0001,
    ERSQ_RUN = 4'b0010,
    ERSQ_HOLD = 4'b0100,
    ERSQ_HALT = 4'b1000
  } ersq_state_t;

  typedef enum logic [3:0] {
    GRP_NONE = 4'h0,
    GRP_EXC = 4'h1,
    GRP_OVL = 4'h2,
    GRP_STK = 4'h3,
    GRP_UNI = 4'h4,
    GRP_COM = 4'h5,
    GRP_ETH = 4'h6,
    GRP_ALC = 4'h7
  } ersq_grp_t;
endpackage : ersq_pkg

// [common/ersq_core_if.sv]
// carrier between the sequencer core, pin synchroniser and alert classifier
`timescale 1ns/10ps
interface ersq_core_if;
  logic [42:0] pin_raw;
  logic [42:0] pin_clean;
  logic [15:0] code;
  ersq_pkg::ersq_grp_t grp;
  modport sync (input pin_raw, output pin_clean);
  modport cls (input code, output grp);
  modport core (output pin_raw, output code, input pin_clean, input grp);
endinterface : ersq_core_if

// [rtl/ersq_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module ersq_sync (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins
  ersq_core_if.sync pins
);
  typedef struct packed {
    logic [42:0] s1;
    logic [42:0] s2;
    logic [42:0] s3;
    logic [42:0] clean;
  } ersq_sync_t;

  ersq_sync_t s_q;
  ersq_sync_t s_d;

  // only s2 reads s1; clean follows s3 once s2 and s3 agree
  always_comb begin
    s_d = s_q;
    s_d.s1 = pins.pin_raw;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.clean = (s_q.s3 & ~(s_q.s2 ^ s_q.s3)) | (s_q.clean & (s_q.s2 ^ s_q.s3));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins.pin_clean = s_q.clean;
endmodule : ersq_sync

// [rtl/ersq_alert_class.sv]
// sorts a run-time alert code into its cause group
`timescale 1ns/10ps
module ersq_alert_class (
  // code in, group out
  ersq_core_if.cls alert
);
  always_comb begin
    alert.grp = ersq_pkg::GRP_NONE;
    if (alert.code >= ersq_pkg::GRP_EXC_LO && alert.code <= ersq_pkg::GRP_EXC_HI) begin
      alert.grp = ersq_pkg::GRP_EXC;
    end else if (alert.code >= ersq_pkg::GRP_OVL_LO && alert.code <= ersq_pkg::GRP_OVL_HI) begin
      alert.grp = ersq_pkg::GRP_OVL;
    end else if (alert.code == ersq_pkg::GRP_STACK) begin
      alert.grp = ersq_pkg::GRP_STK;
    end else if (alert.code == ersq_pkg::GRP_UNINIT) begin
      alert.grp = ersq_pkg::GRP_UNI;
    end else if (alert.code >= ersq_pkg::GRP_COMMS_LO && alert.code <= ersq_pkg::GRP_COMMS_HI) begin
      alert.grp = ersq_pkg::GRP_COM;
    end else if (alert.code >= ersq_pkg::GRP_ETH_LO && alert.code <= ersq_pkg::GRP_ETH_HI) begin
      alert.grp = ersq_pkg::GRP_ETH;
    end else if (alert.code >= ersq_pkg::GRP_ALLOC_LO && alert.code <= ersq_pkg::GRP_ALLOC_HI) begin
      alert.grp = ersq_pkg::GRP_ALC;
    end
  end
endmodule : ersq_alert_class

// [rtl/ersq_top.sv]
// emergency run sequencer with its register slave
//
// Contract
// - zero setpoint: activation flag does nothing
// - nonzero setpoint plus flag: run while active
// - running keeps running, stopped drive auto-starts
// - run withdrawn only for listed stop causes
// - only trips 1, 3, 4 stop drive
// - enabled trip: hold, then restart once clear
// - emergency overrides normal start/stop and reference
// - deactivation restores previous sequencing mode
// - local stops on exit, remote follows word
// - errors raise alert with code 0-65000
// - without keypad show only alert number one
// - alert codes grouped by cause ranges
`timescale 1ns/10ps
module ersq_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // register bus write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // register bus write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // register bus read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // register bus read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // stop sources, from pins
  input wire logic coast_stop,
  input wire logic safe_torque_off_input,
  input wire logic hw_fault,
  input wire logic [36:0] trip_active,
  // normal sequencing, from pins
  input wire logic local_start,
  input wire logic local_stop,
  input wire logic keypad_present,
  // normal speed reference, same clock
  input wire logic [15:0] normal_speed_ref,
  // error reports, same clock
  input wire logic alert_event,
  input wire logic [15:0] alert_code,
  // power stage
  output logic run_cmd,
  output logic [15:0] speed_ref,
  output logic emergency_active,
  // alert display
  output logic runtime_alert,
  output logic [15:0] runtime_alert_code,
  output logic runtime_alert_short_display,
  output logic [7:0] alert_number_one
);
  typedef struct packed {
    ersq_pkg::ersq_state_t st;
    logic [2:0] ctrl;
    logic [15:0] sp;
    logic saved_remote;
    logic local_run;
    logic run;
    logic emerg;
    logic [15:0] spd;
    logic alert_v;
    logic [15:0] alert_c;
    logic [3:0] alert_g;
    logic [15:0] code_o;
    logic short_o;
    logic [7:0] num_o;
    logic aw_h;
    logic aw_hit;
    logic [4:0] aw_a;
    logic w_h;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } ersq_top_t;

  ersq_top_t s_q;
  ersq_top_t s_d;

  ersq_core_if core ();

  logic [15:0] code_sat;
  logic [42:0] p;
  logic [36:0] trips;
  logic engage;
  logic kept;
  logic stopper;
  logic keypad;
  logic ar_hit;
  logic [4:0] ar_a;
  logic [31:0] stat_w;
  logic [31:0] alert_w;

  // pins cross into the clock domain through the filter
  assign core.pin_raw = {keypad_present, local_stop, local_start, hw_fault,
                         safe_torque_off_input, coast_stop, trip_active};

  ersq_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins(core.sync)
  );

  // out-of-range codes saturate rather than wrap
  assign code_sat = (alert_code > ersq_pkg::ALERT_CODE_MAX) ?
                    ersq_pkg::ALERT_CODE_MAX : alert_code;
  assign core.code = code_sat;

  ersq_alert_class u_cls (
    .alert(core.cls)
  );

  assign p = core.pin_clean;
  assign trips = p[36:0];
  assign keypad = p[ersq_pkg::PIN_KEYPAD];
  assign stopper = p[ersq_pkg::PIN_COAST] | p[ersq_pkg::PIN_STO] | p[ersq_pkg::PIN_HWF];
  assign kept = |(trips & ersq_pkg::TRIP_KEEP_MASK);
  assign engage = s_q.ctrl[ersq_pkg::CTRL_ACT_BIT] & (s_q.sp != 16'h0000);
  assign ar_hit = (s_axi_araddr[31:5] == 27'h0000000);
  assign ar_a = s_axi_araddr[4:0];

  always_comb begin
    stat_w = 32'h0000_0000;
    stat_w[ersq_pkg::STAT_EMERG_BIT] = s_q.emerg;
    stat_w[ersq_pkg::STAT_RUN_BIT] = s_q.run;
    stat_w[ersq_pkg::STAT_HOLD_BIT] = (s_q.st == ersq_pkg::ERSQ_HOLD);
    stat_w[ersq_pkg::STAT_HALT_BIT] = (s_q.st == ersq_pkg::ERSQ_HALT);
    stat_w[ersq_pkg::STAT_SAVED_BIT] = s_q.saved_remote;
    stat_w[ersq_pkg::STAT_KEYPAD_BIT] = keypad;
    alert_w = 32'h0000_0000;
    alert_w[15:0] = s_q.alert_c;
    alert_w[ersq_pkg::ALERT_VALID_BIT] = s_q.alert_v;
    alert_w[ersq_pkg::ALERT_GRP_LSB +: 4] = s_q.alert_g;
  end

  always_comb begin
    s_d = s_q;
    // write channels are taken independently and held until both arrive
    if (s_axi_awvalid && !s_q.aw_h) begin
      s_d.aw_h = 1'b1;
      s_d.aw_a = s_axi_awaddr[4:0];
      s_d.aw_hit = (s_axi_awaddr[31:5] == 27'h0000000);
    end
    if (s_axi_wvalid && !s_q.w_h) begin
      s_d.w_h = 1'b1;
      s_d.wd = s_axi_wdata;
      s_d.ws = s_axi_wstrb;
    end
    if (s_q.bv && s_axi_bready) begin
      s_d.bv = 1'b0;
    end
    if (s_q.aw_h && s_q.w_h && !s_q.bv) begin
      s_d.aw_h = 1'b0;
      s_d.w_h = 1'b0;
      s_d.bv = 1'b1;
      s_d.br = ersq_pkg::RESP_OKAY;
      if (s_q.aw_hit && s_q.aw_a == ersq_pkg::CTRL_OFF) begin
        if (s_q.ws[0]) begin
          s_d.ctrl = s_q.wd[2:0];
        end
      end else if (s_q.aw_hit && s_q.aw_a == ersq_pkg::SP_OFF) begin
        if (s_q.ws[0]) begin
          s_d.sp[7:0] = s_q.wd[7:0];
        end
        if (s_q.ws[1]) begin
          s_d.sp[15:8] = s_q.wd[15:8];
        end
      end else if (s_q.aw_hit && s_q.aw_a == ersq_pkg::STAT_OFF) begin
        s_d.br = ersq_pkg::RESP_OKAY;
      end else if (s_q.aw_hit && s_q.aw_a == ersq_pkg::ALERT_OFF) begin
        s_d.alert_v = 1'b0;
      end else begin
        s_d.br = ersq_pkg::RESP_SLVERR;
      end
    end
    // read: one word in flight, answered the cycle after it is taken
    if (s_q.rv && s_axi_rready) begin
      s_d.rv = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rv) begin
      s_d.rv = 1'b1;
      s_d.rr = ersq_pkg::RESP_OKAY;
      if (ar_hit && ar_a == ersq_pkg::CTRL_OFF) begin
        s_d.rd = {29'h0000_0000, s_q.ctrl};
      end else if (ar_hit && ar_a == ersq_pkg::SP_OFF) begin
        s_d.rd = {16'h0000, s_q.sp};
      end else if (ar_hit && ar_a == ersq_pkg::STAT_OFF) begin
        s_d.rd = stat_w;
      end else if (ar_hit && ar_a == ersq_pkg::ALERT_OFF) begin
        s_d.rd = alert_w;
      end else begin
        s_d.rd = 32'h0000_0000;
        s_d.rr = ersq_pkg::RESP_SLVERR;
      end
    end
    // local start/stop latch only listens outside emergency run
    if (s_q.st == ersq_pkg::ERSQ_NORMAL) begin
      if (p[ersq_pkg::PIN_LSTOP]) begin
        s_d.local_run = 1'b0;
      end else if (p[ersq_pkg::PIN_LSTART]) begin
        s_d.local_run = 1'b1;
      end
    end
    case (s_q.st)
      ersq_pkg::ERSQ_NORMAL: begin
        if (engage) begin
          s_d.saved_remote = s_q.ctrl[ersq_pkg::CTRL_REMOTE_BIT];
          s_d.st = ersq_pkg::ERSQ_RUN;
        end
      end
      ersq_pkg::ERSQ_RUN: begin
        if (!engage) begin
          s_d.st = ersq_pkg::ERSQ_NORMAL;
        end else if (stopper) begin
          s_d.st = ersq_pkg::ERSQ_HALT;
        end else if (kept) begin
          s_d.st = ersq_pkg::ERSQ_HOLD;
        end
      end
      ersq_pkg::ERSQ_HOLD: begin
        if (!engage) begin
          s_d.st = ersq_pkg::ERSQ_NORMAL;
        end else if (stopper) begin
          s_d.st = ersq_pkg::ERSQ_HALT;
        end else if (!kept) begin
          s_d.st = ersq_pkg::ERSQ_RUN;
        end
      end
      ersq_pkg::ERSQ_HALT: begin
        if (!engage) begin
          s_d.st = ersq_pkg::ERSQ_NORMAL;
        end else if (!stopper) begin
          s_d.st = kept ? ersq_pkg::ERSQ_HOLD : ersq_pkg::ERSQ_RUN;
        end
      end
      default: begin
        s_d.st = ersq_pkg::ERSQ_NORMAL;
      end
    endcase
    // leaving emergency run puts the saved mode back
    if (s_q.st != ersq_pkg::ERSQ_NORMAL && s_d.st == ersq_pkg::ERSQ_NORMAL) begin
      s_d.ctrl[ersq_pkg::CTRL_REMOTE_BIT] = s_q.saved_remote;
      if (!s_q.saved_remote) begin
        s_d.local_run = 1'b0;
      end
    end
    s_d.emerg = (s_d.st != ersq_pkg::ERSQ_NORMAL);
    if (s_d.emerg) begin
      // trips other than the kept ones are ignored here
      s_d.run = (s_d.st == ersq_pkg::ERSQ_RUN) && !stopper && !kept;
      s_d.spd = s_q.sp;
    end else begin
      // remote mode keeps following the control word
      // restored mode counts in the exit cycle, so remote runs on without a gap
      s_d.run = (s_d.ctrl[ersq_pkg::CTRL_REMOTE_BIT] ? s_d.ctrl[ersq_pkg::CTRL_RRUN_BIT] :
                 s_d.local_run) && !stopper && !(|trips);
      s_d.spd = normal_speed_ref;
    end
    // set wins over a clear in the same cycle
    if (alert_event) begin
      s_d.alert_v = 1'b1;
      s_d.alert_c = code_sat;
      s_d.alert_g = core.grp;
    end
    // without the detailed keypad no code is shown at all
    s_d.short_o = s_d.alert_v && !keypad;
    s_d.num_o = s_d.short_o ? ersq_pkg::ALERT_NUMBER_ONE : 8'h00;
    s_d.code_o = (s_d.alert_v && keypad) ? s_d.alert_c : 16'h0000;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.st <= ersq_pkg::ERSQ_NORMAL;
      s_q.ctrl <= ersq_pkg::CTRL_RST;
      s_q.sp <= ersq_pkg::SP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = !s_q.aw_h;
  assign s_axi_wready = !s_q.w_h;
  assign s_axi_bvalid = s_q.bv;
  assign s_axi_bresp = s_q.br;
  assign s_axi_arready = !s_q.rv;
  assign s_axi_rvalid = s_q.rv;
  assign s_axi_rdata = s_q.rd;
  assign s_axi_rresp = s_q.rr;
  assign run_cmd = s_q.run;
  assign speed_ref = s_q.spd;
  assign emergency_active = s_q.emerg;
  assign runtime_alert = s_q.alert_v;
  assign runtime_alert_code = s_q.code_o;
  assign runtime_alert_short_display = s_q.short_o;
  assign alert_number_one = s_q.num_o;
endmodule : ersq_top

// [sim/ersq_top_asserts.sv]
// port checker for the emergency run sequencer
`timescale 1ns/10ps
module ersq_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // causes
  input wire logic coast_stop,
  input wire logic safe_torque_off_input,
  input wire logic hw_fault,
  input wire logic [36:0] trip_active,
  input wire logic [15:0] normal_speed_ref,
  input wire logic alert_event,
  // effects
  input wire logic run_cmd,
  input wire logic [15:0] speed_ref,
  input wire logic emergency_active,
  input wire logic runtime_alert,
  input wire logic [15:0] runtime_alert_code,
  input wire logic runtime_alert_short_display,
  input wire logic [7:0] alert_number_one
);
  logic stop_pin;
  logic keep_trip;
  assign stop_pin = coast_stop || safe_torque_off_input || hw_fault;
  assign keep_trip = (trip_active & ersq_pkg::TRIP_KEEP_MASK) != 37'h0;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // six samples cover the pin filter plus state and run updates
  chk_stop_pins: assert property (stop_pin [*6] |-> !run_cmd)
    else $error("run held through a stop input");
  chk_trip_hold: assert property ((emergency_active && keep_trip) [*6] |-> !run_cmd)
    else $error("run held through an enabled trip");
  chk_emerg_runs: assert property (
    (emergency_active && !stop_pin && !keep_trip) [*6] |-> run_cmd)
    else $error("emergency mode without run");
  chk_speed_norm: assert property (
    !emergency_active && !$past(emergency_active) && $past(aresetn)
    |-> speed_ref == $past(normal_speed_ref))
    else $error("normal reference not passed");
  chk_alert_set: assert property (alert_event |=> runtime_alert)
    else $error("alert not raised");
  chk_code_range: assert property (
    runtime_alert |-> runtime_alert_code <= ersq_pkg::ALERT_CODE_MAX)
    else $error("alert code out of range");
  chk_short_only: assert property (runtime_alert_short_display |->
    runtime_alert && alert_number_one == 8'h01 && runtime_alert_code == 16'h0000)
    else $error("short display shows more");
  chk_number_idle: assert property (
    !runtime_alert_short_display |-> alert_number_one == 8'h00)
    else $error("alert number without short display");
endmodule : ersq_checker

bind ersq_top ersq_checker ersq_checker_inst (.aclk, .aresetn, .coast_stop,
  .safe_torque_off_input, .hw_fault, .trip_active, .normal_speed_ref, .alert_event,
  .run_cmd, .speed_ref, .emergency_active, .runtime_alert, .runtime_alert_code,
  .runtime_alert_short_display, .alert_number_one);

// [sim/ersq_stage_model.sv]
// power stage and trip source model facing the sequencer
`timescale 1ns/10ps
module ersq_stage_model (
  // clock
  input wire logic aclk,
  // requests from the bench
  input wire logic [5:0] trip_id,
  input wire logic [2:0] stop_sel,
  // pins towards the sequencer
  output logic [36:0] trip_active,
  output logic coast_stop,
  output logic safe_torque_off_input,
  output logic hw_fault,
  // run command and start count
  input wire logic run_cmd,
  output int starts
);
  logic run_q = 1'b0;
  // pins are levels, so they follow the request right after the edge
  assign trip_active = (trip_id == 6'h00) ? 37'h0 : (37'h1 << (trip_id - 6'h01));
  assign coast_stop = stop_sel[0];
  assign safe_torque_off_input = stop_sel[1];
  assign hw_fault = stop_sel[2];
  initial starts = 0;
  // counting starts shows restarts that nobody commanded
  always @(posedge aclk) begin
    if (run_cmd === 1'b1 && run_q === 1'b0) starts <= starts + 1;
    run_q <= run_cmd;
  end
endmodule : ersq_stage_model

// [sim/tb.sv]
// self-checking bench for the emergency run sequencer
`timescale 1ns/10ps
module tb;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic local_start = 1'b0, local_stop = 1'b0, keypad_present = 1'b1, alert_event = 1'b0;
  logic [15:0] alert_code = 16'h0, normal_speed_ref = 16'h0, speed_ref, runtime_alert_code;
  logic [5:0] trip_id = 6'h00;
  logic [2:0] stop_sel = 3'h0;
  logic [36:0] trip_active;
  logic coast_stop, safe_torque_off_input, hw_fault, run_cmd, emergency_active;
  logic runtime_alert, runtime_alert_short_display;
  logic [7:0] alert_number_one;
  int starts, n0, bad_count = 0, cmp_count = 0;
  logic [15:0] codes [10] = '{16'h0001, 16'h03e7, 16'h03e9, 16'h03ee, 16'h03f2, 16'h04b5,
    16'h0546, 16'h07d2, 16'h03e8, 16'hffff};
  logic [3:0] grps [10] = '{4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h0, 4'h0};

  ersq_top ersq_top_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .coast_stop,
    .safe_torque_off_input, .hw_fault, .trip_active, .local_start, .local_stop,
    .keypad_present, .normal_speed_ref, .alert_event, .alert_code, .run_cmd, .speed_ref,
    .emergency_active, .runtime_alert, .runtime_alert_code, .runtime_alert_short_display,
    .alert_number_one);
  ersq_stage_model ersq_stage_model_inst (.aclk, .trip_id, .stop_sel, .trip_active,
    .coast_stop, .safe_torque_off_input, .hw_fault, .run_cmd, .starts);

  always #50 aclk = ~aclk;

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : tick

  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic wr(input logic [4:0] o, input logic [31:0] v, output logic [1:0] rs);
    logic aw;
    logic w;
    logic a_ok;
    logic w_ok;
    logic b_ok;
    @(posedge aclk);
    s_axi_awaddr <= {27'h0, o};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    // readies are read between edges, where they stand still
    while (!(aw && w)) begin
      #1;
      a_ok = !aw && s_axi_awready === 1'b1;
      w_ok = !w && s_axi_wready === 1'b1;
      @(posedge aclk);
      if (a_ok) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (w_ok) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      #1;
      b_ok = s_axi_bvalid === 1'b1;
      rs = s_axi_bresp;
      @(posedge aclk);
    end while (!b_ok);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] o, output logic [31:0] v, output logic [1:0] rs);
    logic a_ok;
    logic r_ok;
    @(posedge aclk);
    s_axi_araddr <= {27'h0, o};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      #1;
      a_ok = s_axi_arready === 1'b1;
      @(posedge aclk);
    end while (!a_ok);
    s_axi_arvalid <= 1'b0;
    do begin
      #1;
      r_ok = s_axi_rvalid === 1'b1;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
    end while (!r_ok);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic results;
    $display("compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // bound is far above the under a thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    tick(6);
    rd(ersq_pkg::SP_OFF, d, r);
    chk(d === 32'h0 && r === ersq_pkg::RESP_OKAY, "setpoint reset");
    wr(ersq_pkg::STAT_OFF, 32'hff, r);
    rd(ersq_pkg::STAT_OFF, d, r);
    chk(d === 32'h20, "status read only");
    rd(5'h10, d, r);
    chk(d === 32'h0 && r === ersq_pkg::RESP_SLVERR, "unmapped read");
    wr(ersq_pkg::CTRL_OFF, 32'h1, r);
    tick(6);
    chk(emergency_active === 1'b0 && run_cmd === 1'b0, "zero setpoint engaged");
    $display("test registers done");
    @(posedge aclk);
    normal_speed_ref <= 16'h0055;
    local_start <= 1'b1;
    tick(8);
    chk(run_cmd === 1'b1 && speed_ref === 16'h0055, "local start");
    @(posedge aclk);
    local_start <= 1'b0;
    n0 = starts;
    wr(ersq_pkg::SP_OFF, 32'h1234, r);
    tick(3);
    chk(emergency_active === 1'b1 && run_cmd === 1'b1, "no emergency run");
    chk(starts == n0, "running drive restarted");
    chk(speed_ref === 16'h1234, "reference not overridden");
    @(posedge aclk);
    local_stop <= 1'b1;
    n0 = starts;
    for (int i = 1; i <= 37; i++) begin
      @(posedge aclk);
      trip_id <= 6'(i);
      tick(6);
      chk(run_cmd === ((i == 1 || i == 3 || i == 4) ? 1'b0 : 1'b1), "trip mask");
      @(posedge aclk);
      trip_id <= 6'h00;
      tick(6);
      chk(run_cmd === 1'b1 && emergency_active === 1'b1, "no restart");
    end
    chk(starts == n0 + 3, "restart count");
    for (int j = 0; j < 3; j++) begin
      @(posedge aclk);
      stop_sel <= 3'(1 << j);
      tick(6);
      chk(run_cmd === 1'b0, "stop input ignored");
      @(posedge aclk);
      stop_sel <= 3'h0;
      tick(6);
      chk(run_cmd === 1'b1, "stop release");
    end
    $display("test trips done");
    @(posedge aclk);
    local_stop <= 1'b0;
    wr(ersq_pkg::CTRL_OFF, 32'h0, r);
    tick(3);
    chk(emergency_active === 1'b0 && run_cmd === 1'b0, "local exit");
    wr(ersq_pkg::CTRL_OFF, 32'h6, r);
    wr(ersq_pkg::CTRL_OFF, 32'h7, r);
    for (int k = 0; k < 4; k++) begin
      tick(1);
      chk(run_cmd === 1'b1, "running drive stopped");
    end
    n0 = starts;
    // remote bit dropped during emergency, exit through a zero setpoint
    wr(ersq_pkg::CTRL_OFF, 32'h5, r);
    wr(ersq_pkg::SP_OFF, 32'h0, r);
    tick(3);
    chk(emergency_active === 1'b0 && run_cmd === 1'b1, "remote exit");
    chk(starts == n0, "remote exit gap");
    rd(ersq_pkg::CTRL_OFF, d, r);
    chk(d === 32'h7, "mode not restored");
    $display("test modes done");
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      alert_event <= 1'b1;
      alert_code <= codes[i];
      @(posedge aclk);
      alert_event <= 1'b0;
      #1;
      chk(runtime_alert === 1'b1 && runtime_alert_code === ((codes[i] >
        ersq_pkg::ALERT_CODE_MAX) ? ersq_pkg::ALERT_CODE_MAX : codes[i]), "alert code");
      rd(ersq_pkg::ALERT_OFF, d, r);
      chk(d[23:20] === grps[i] && d[16] === 1'b1, "alert group");
      wr(ersq_pkg::ALERT_OFF, 32'h0, r);
    end
    tick(2);
    chk(runtime_alert === 1'b0, "alert clear");
    @(posedge aclk);
    keypad_present <= 1'b0;
    tick(6);
    @(posedge aclk);
    alert_event <= 1'b1;
    alert_code <= 16'h03ee;
    @(posedge aclk);
    alert_event <= 1'b0;
    #1;
    chk(runtime_alert_short_display === 1'b1 && alert_number_one === 8'h01 &&
      runtime_alert_code === 16'h0000, "short display");
    $display("test alerts done");
    results();
  end
endmodule : tb
